// >>> rtl/sbs_control.sv
/*
 sbs_control: synchronous burst SRAM control, burst counter, write and
 output-enable logic, small flip-flop array, read data through a FIFO.
 assumes host drives inputs on clk falling edges; data pins split in/out/oe.
*/
`timescale 1ns/1ps
module sbs_control
  import sbs_pkg::*;
#(
  parameter int ADDR_W = SBS_ADDR_W,
  parameter int LANE_W = SBS_LANE_W,
  parameter int LANES = SBS_LANES_WIDE
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire sbs_ctl_t ctl,
  input wire logic [LANES-1:0] lane_write_n,
  input wire sbs_mode_t mode,
  input wire logic output_enable_n,
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic [LANES*LANE_W-1:0] data_oe,
  output logic [1:0] burst_addr,
  output logic standby,
  output logic rd_valid,
  output logic [LANES*LANE_W-1:0] rd_data,
  input wire logic rd_ready,
  output logic stall
);
  localparam int DW = LANES*LANE_W;
  localparam int WORDS = 1 << ADDR_W;

  function automatic logic wr_cond(input sbs_ctl_t c);
    return !(c.global_write_n && c.byte_write_enable_n);
  endfunction

  function automatic sbs_op_t decode(input sbs_ctl_t c);
    if (!c.chip_select_n && !c.cpu_strobe_n) begin
      return SBS_OP_BEGIN;
    end else if (!c.ctrl_strobe_n) begin
      return c.chip_select_n ? SBS_OP_DESEL : SBS_OP_BEGIN;
    end else if (!c.counter_step_n) begin
      return SBS_OP_CONT;
    end else begin
      return SBS_OP_HOLD;
    end
  endfunction

  sbs_op_t op;
  logic is_wr;
  logic rd_forced;
  logic [1:0] start_r;
  logic [1:0] step_r;
  logic [ADDR_W-1:0] base_r;
  logic [ADDR_W-1:0] cur_addr;
  logic [1:0] nxt_step;
  logic [1:0] lo_bits;
  logic [LANE_W-1:0] mem_r [LANES][WORDS];
  logic [DW-1:0] rd_word;
  logic [DW-1:0] pipe_r;
  logic rd_now;
  logic rd_act_r;
  logic rd_act_d_r;
  logic desel_d_r;
  logic drive;
  logic fifo_ready;
  logic [LANES-1:0] lane_we;

  assign op = decode(ctl);
  assign is_wr = (op != SBS_OP_DESEL) && !rd_forced && wr_cond(ctl);
  // a cpu-strobe begin is never a write
  assign rd_forced = !ctl.chip_select_n && !ctl.cpu_strobe_n;
  assign standby = mode.sleep_request;
  assign rd_now = !standby && (op != SBS_OP_DESEL) && !is_wr;

  // burst address: linear adds, interleaved xors the step count
  assign nxt_step = step_r + 2'h1;
  assign lo_bits = mode.linear_order_n ? (start_r ^ step_r) : (start_r + step_r);
  assign burst_addr = lo_bits;
  assign cur_addr = {base_r[ADDR_W-1:2], lo_bits};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_r <= SBS_CNT_RST;
      step_r <= SBS_CNT_RST;
      base_r <= '0;
    end else if (clk_en && !standby) begin
      case (op)
        SBS_OP_BEGIN: begin
          base_r <= addr;
          start_r <= addr[1:0];
          step_r <= SBS_CNT_RST;
        end
        SBS_OP_CONT: begin
          step_r <= nxt_step;
        end
        SBS_OP_HOLD: begin
          step_r <= step_r;
        end
        default: begin
          step_r <= step_r;
        end
      endcase
    end
  end

  // access address is the one selected this cycle
  logic [ADDR_W-1:0] acc_addr;
  always_comb begin
    case (op)
      SBS_OP_BEGIN: acc_addr = addr;
      SBS_OP_CONT: begin
        acc_addr = {base_r[ADDR_W-1:2],
          mode.linear_order_n ? (start_r ^ nxt_step) : (start_r + nxt_step)};
      end
      default: acc_addr = cur_addr;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_we[g] = !ctl.global_write_n || !lane_write_n[g];
      always_ff @(posedge clk) begin
        if (clk_en && !standby && is_wr && lane_we[g]) begin
          mem_r[g][acc_addr] <= data_in[g*LANE_W +: LANE_W];
        end
      end
      assign rd_word[g*LANE_W +: LANE_W] = mem_r[g][acc_addr];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pipe_r <= '0;
      rd_act_r <= 1'b0;
      rd_act_d_r <= 1'b0;
      desel_d_r <= 1'b1;
    end else if (clk_en && !stall) begin
      pipe_r <= rd_word;
      rd_act_r <= rd_now;
      rd_act_d_r <= rd_act_r;
      desel_d_r <= !rd_act_r;
    end
  end

  // flow-through loads at the read edge itself; pipelined one edge later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_out <= '0;
    end else if (clk_en && !stall) begin
      if (!mode.flowthru_select_n && rd_now) begin
        data_out <= rd_word;
      end else if (mode.flowthru_select_n && rd_act_r) begin
        data_out <= pipe_r;
      end
    end
  end

  // pipelined: single deselect cuts drive with the read path stage, dual one later; flow-through cuts with the read path stage in both
  always_comb begin
    if (!mode.flowthru_select_n) begin
      drive = rd_act_r;
    end else if (mode.deselect_latency_sel) begin
      drive = rd_act_d_r && rd_act_r;
    end else begin
      drive = rd_act_d_r || (!desel_d_r && rd_act_r);
    end
  end
  assign data_oe = {DW{drive && !output_enable_n && !is_wr && !standby}};

  sbs_fifo #(
    .WIDTH(DW),
    .DEPTH(SBS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_data(data_out),
    .in_valid(drive),
    .in_ready(fifo_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );
  assign stall = !fifo_ready;

  a_wr_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
    is_wr |-> data_oe == '0) else $error("drivers on during write");
  a_oe_gate: assert property (@(posedge clk) disable iff (sys_rst)
    output_enable_n |-> data_oe == '0) else $error("drive with oe high");
  a_begin_load: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !standby && op == SBS_OP_BEGIN) |=> start_r == $past(addr[1:0]))
    else $error("start not loaded");
  a_hold_addr: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !standby && op == SBS_OP_HOLD) |=> $stable(burst_addr))
    else $error("hold moved address");
  a_wrap_four: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && !standby && op == SBS_OP_CONT && step_r == 2'h3) |=> burst_addr == start_r)
    else $error("burst did not wrap");
  a_read_cond: assert property (@(posedge clk) disable iff (sys_rst)
    (op == SBS_OP_CONT && ctl.global_write_n && ctl.byte_write_enable_n) |-> !is_wr)
    else $error("read made write");
  a_desel_nowr: assert property (@(posedge clk) disable iff (sys_rst)
    (op == SBS_OP_DESEL) |-> !is_wr) else $error("write in deselect");
  a_cpu_read: assert property (@(posedge clk) disable iff (sys_rst)
    (!ctl.chip_select_n && !ctl.cpu_strobe_n) |-> !is_wr)
    else $error("cpu strobe wrote");
endmodule : sbs_control

// >>> rtl/sbs_fifo.sv
/*
 sbs_fifo: flip-flop FIFO with valid/ready on both sides.
 assumes one clock shared with its source and sink.
*/
`timescale 1ns/1ps
module sbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];
  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sbs_fifo

// >>> rtl/sbs_pkg.sv
/*
 sbs_pkg: constants and carrier types of the burst SRAM control block.
 assumes nothing of its surroundings.
*/
package sbs_pkg;
  localparam int SBS_ADDR_W = 10;
  localparam int SBS_LANE_W = 9;
  localparam int SBS_LANES_WIDE = 4;
  localparam int SBS_LANES_NARROW = 2;
  localparam logic [1:0] SBS_CNT_RST = 2'h0;
  localparam int SBS_FIFO_DEPTH = 16;
  localparam int SBS_CLK_HZ = 10000000;

  typedef enum logic [1:0] {
    SBS_OP_DESEL = 2'b00,
    SBS_OP_BEGIN = 2'b01,
    SBS_OP_CONT = 2'b10,
    SBS_OP_HOLD = 2'b11
  } sbs_op_t;

  typedef struct packed {
    logic chip_select_n;
    logic cpu_strobe_n;
    logic ctrl_strobe_n;
    logic counter_step_n;
    logic global_write_n;
    logic byte_write_enable_n;
  } sbs_ctl_t;

  typedef struct packed {
    logic linear_order_n;
    logic flowthru_select_n;
    logic deselect_latency_sel;
    logic sleep_request;
  } sbs_mode_t;
endpackage : sbs_pkg

// >>> tb/sbs_control_bench.sv
/*
 sbs_control_bench: directed checks of the burst SRAM control.
 assumes sbs_host drives the control pins.
*/
`timescale 1ns/1ps
module sbs_control_bench
  import sbs_pkg::*;
;
  localparam sbs_ctl_t RP = 6'h0F, RC = 6'h17, WG = 6'h15, WB = 6'h16;
  localparam sbs_ctl_t CT = 6'h3B, HD = 6'h3F, DS = 6'h27;
  logic clk = 0, sys_rst = 1, oe_n = 0, rd_ready = 1;
  sbs_mode_t mode = 4'h2;
  logic [9:0] addr;
  sbs_ctl_t ctl;
  logic [3:0] lwn;
  logic [35:0] din, dout, doe, rdd;
  logic [1:0] ba, e;
  logic stby, rdv, stall;
  int fail_count = 0, comparisons = 0, cycles = 0, k;
  always #50 clk = ~clk;
  sbs_host i_host (.clk(clk), .addr(addr), .ctl(ctl), .lane_write_n(lwn), .data_in(din));
  sbs_control i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .addr(addr), .ctl(ctl),
    .lane_write_n(lwn), .mode(mode), .output_enable_n(oe_n), .data_in(din),
    .data_out(dout), .data_oe(doe), .burst_addr(ba), .standby(stby), .rd_valid(rdv),
    .rd_data(rdd), .rd_ready(rd_ready), .stall(stall));
  task automatic chk_w(input logic [35:0] g, input logic [35:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk_w
  task automatic chk_b(input logic [3:0] g, input logic [3:0] x);
    chk_w({32'h0, g}, {32'h0, x});
  endtask : chk_b
  task automatic go(input sbs_ctl_t c, input logic [9:0] a, input logic [3:0] l,
    input logic [35:0] d);
    i_host.cyc(c, a, l, d);
    @(posedge clk);
    #1;
  endtask : go
  task automatic t_access();
    go(WG, 10'h005, 4'hF, 36'h123456789);
    chk_w(doe, 36'h0);
    go(RP, 10'h005, 4'h0, 36'h0);
    chk_w(dout, 36'h123456789);
    chk_w(doe, '1);
    go(WB, 10'h005, 4'hA, 36'hFEDCBA987);
    go(WB, 10'h005, 4'hF, 36'h0);
    go(RC, 10'h005, 4'hF, 36'h0);
    chk_w(dout, 36'h125C96787);
  endtask : t_access
  task automatic t_pipe();
    go(WG, 10'h006, 4'hF, 36'hABCDE0123);
    @(negedge clk);
    mode.flowthru_select_n = 1'b1;
    go(RP, 10'h006, 4'hF, 36'h0);
    chk_w(dout, 36'h125C96787);
    go(HD, 10'h000, 4'hF, 36'h0);
    chk_w(dout, 36'hABCDE0123);
  endtask : t_pipe
  task automatic t_burst();
    for (int o = 0; o < 2; o++) begin
      @(negedge clk);
      mode.linear_order_n = o[0];
      for (int s = 0; s < 4; s++) begin
        go(RC, {8'h00, s[1:0]}, 4'hF, 36'h0);
        chk_b({2'h0, ba}, s[3:0]);
        for (k = 1; k < 6; k++) begin
          go((k == 5) ? HD : CT, 10'h3FF, 4'hF, 36'h0);
          e = (k == 5) ? 2'h0 : k[1:0];
          e = o[0] ? (s[1:0] ^ e) : (s[1:0] + e);
          chk_b({2'h0, ba}, {2'h0, e});
        end
      end
    end
  endtask : t_burst
  task automatic t_oe();
    go(HD, 10'h000, 4'hF, 36'h0);
    go(HD, 10'h000, 4'hF, 36'h0);
    chk_w(doe, '1);
    @(negedge clk);
    oe_n = 1'b1;
    #1;
    chk_w(doe, 36'h0);
    go(DS, 10'h000, 4'hF, 36'h0);
    go(RC, 10'h004, 4'hF, 36'h0);
    go(CT, 10'h000, 4'hF, 36'h0);
    chk_b({2'h0, ba}, 4'h1);
    @(negedge clk);
    oe_n = 1'b0;
    mode.sleep_request = 1'b1;
    go(CT, 10'h000, 4'hF, 36'h0);
    chk_b({3'h0, stby}, 4'h1);
    chk_b({2'h0, ba}, 4'h1);
    @(negedge clk);
    mode.sleep_request = 1'b0;
    go(DS, 10'h000, 4'hF, 36'h0);
    chk_w(doe, 36'h0);
    go(DS, 10'h000, 4'hF, 36'h0);
    chk_w(doe, 36'h0);
  endtask : t_oe
  task automatic t_dcd();
    @(negedge clk);
    mode.deselect_latency_sel = 1'b0;
    go(RC, 10'h005, 4'hF, 36'h0);
    go(DS, 10'h000, 4'hF, 36'h0);
    chk_w(doe, '1);
    chk_w(dout, 36'h125C96787);
    go(DS, 10'h000, 4'hF, 36'h0);
    chk_w(doe, 36'h0);
    @(negedge clk);
    mode.deselect_latency_sel = 1'b1;
    go(RC, 10'h005, 4'hF, 36'h0);
    go(DS, 10'h000, 4'hF, 36'h0);
    chk_w(doe, 36'h0);
  endtask : t_dcd
  task automatic t_fifo();
    @(negedge clk);
    rd_ready = 1'b0;
    for (k = 0; k < 20; k++) go(RC, 10'h005, 4'hF, 36'h0);
    chk_b({3'h0, stall}, 4'h1);
    chk_w(rdd, 36'h125C96787);
    @(negedge clk);
    rd_ready = 1'b1;
    for (k = 0; k < 40; k++) go(DS, 10'h000, 4'hF, 36'h0);
    chk_b({2'h0, stall, rdv}, 4'h0);
  endtask : t_fifo
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_access();
    t_pipe();
    t_burst();
    t_oe();
    t_dcd();
    t_fifo();
    wrap_up();
  end
endmodule : sbs_control_bench

// >>> tb/sbs_host.sv
/*
 sbs_host: host model driving the control and write data pins.
 assumes the bench calls cyc once per clock.
*/
`timescale 1ns/1ps
module sbs_host
  import sbs_pkg::*;
(
  input wire logic clk,
  output logic [9:0] addr,
  output sbs_ctl_t ctl,
  output logic [3:0] lane_write_n,
  output logic [35:0] data_in
);
  initial begin
    addr = 10'h000;
    ctl = 6'h37;
    lane_write_n = 4'hF;
    data_in = 36'h000000000;
  end
  // pins change at the falling edge; read data lines toggle, never hold
  task automatic cyc(input sbs_ctl_t c, input logic [9:0] a, input logic [3:0] l,
    input logic [35:0] d);
    @(negedge clk);
    ctl <= c;
    addr <= a;
    lane_write_n <= l;
    data_in <= (c.global_write_n & c.byte_write_enable_n) ? ~data_in : d;
  endtask : cyc
endmodule : sbs_host
